// [seei_host_model.sv]
// spi host model for the eeprom front end pins
// assumes a 20 ns clock; sck is 8 clocks a bit, still outside frames
`timescale 1ns/1ps
module seei_host_model (
  input wire logic clk_i,
  input wire logic so_i,
  input wire logic so_oe_n_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  output logic pause_n_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    pause_n_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // ----
  // frame control
  // ----
  task automatic sel(input logic on);
    tick(1);
    cs_n_o <= ~on;
    if (!on) si_o <= ~si_o;
    tick(6);
  endtask
  // a released output reads as unknown, so it can never match
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      tick(1);
      si_o <= tx[i];
      tick(3);
      sck_o <= 1'b1;
      tick(3);
      rx[i] = so_oe_n_i ? 1'bx : so_i;
      tick(1);
      sck_o <= 1'b0;
    end
  endtask
  task automatic hold(output logic off);
    tick(1);
    pause_n_o <= 1'b0;
    repeat (4) begin
      tick(2);
      sck_o <= ~sck_o;
      si_o <= ~si_o;
    end
    off = so_oe_n_i;
    tick(2);
    pause_n_o <= 1'b1;
    tick(4);
  endtask
endmodule

// [seei_mem.sv]
// byte memory of the array
// assumes same-clock writes; read data come out of a register
`timescale 1ns/1ps
module seei_mem (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [9:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [9:0] raddr_i,
  output logic [7:0] rdata_o
);
  import seei_pkg::*;
  logic [7:0] mem [MEM_DEPTH];
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

// [seei_pkg.sv]
// package for the serial eeprom command front end
// assumes a single 50 MHz core clock; pins are sampled, not used as clocks
package seei_pkg;
  localparam int ADDR_W = 10;
  localparam int MEM_DEPTH = 1024;
  localparam logic [9:0] ADDR_LAST = 10'h3FF;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [5:0] PAGE_BYTES = 6'h20;
  localparam int PAGE_SMALL = 16;
  localparam int PAGE_LARGE = 32;
  localparam int OPC_BITS = 8;
  localparam int ADDR_BITS = 16;
  localparam int CLK_HZ = 50000000;
  localparam int WRITE_MS = 5;
  localparam int WRITE_CYC = (CLK_HZ / 1000) * WRITE_MS;
  localparam int BUSY_POS = 0;
  localparam int LATCH_POS = 1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [4:0] BITCNT_RST = 5'h00;
  typedef enum logic [2:0] {
    SEEI_OPC, SEEI_ADDR, SEEI_RDATA, SEEI_WDATA, SEEI_SREAD, SEEI_SWRITE,
    SEEI_IDLE
  } seei_state_t;
endpackage

// [seei_top.sv]
// spi eeprom command front end: pause, opcode decode, reads, page writes
// assumes pins are asynchronous and sampled by ref_clk_i; one clock only
`timescale 1ns/1ps
module seei_top
  import seei_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic pause_n_i,
  input wire logic page_large_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic write_busy_flag_o,
  output logic write_latch_flag_o
);
  import seei_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic sck_old_q, sck_old_d, cs_old_q, cs_old_d;
  assign sync1_d = {cs_n_i, sck_i, si_i, pause_n_i};
  assign sync2_d = sync1_q;
  logic cs_n, sck, si, pause_n;
  assign {cs_n, sck, si, pause_n} = sync2_q;
  assign sck_old_d = sck;
  assign cs_old_d = cs_n;
  wire sck_rise = sck & ~sck_old_q;
  wire sck_fall = ~sck & sck_old_q;
  wire cs_rise = cs_n & ~cs_old_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // reset to the idle pin levels so no false clock edge follows reset
      sync1_q <= 4'h9;
      sync2_q <= 4'h9;
      sck_old_q <= 1'b0;
      cs_old_q <= 1'b1;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sck_old_q <= sck_old_d;
      cs_old_q <= cs_old_d;
    end
  end

  // ----------------------------------------------------------------
  // pause tracking
  // ----------------------------------------------------------------
  // paused_q gates shifting; it changes with clock low or on a fall, and clears on deselect
  logic paused_q, paused_d;
  always_comb begin
    paused_d = paused_q;
    if (cs_n) begin
      paused_d = 1'b0;
    end else if (pause_n != paused_q) begin
      paused_d = paused_q;
    end else if (!sck || sck_fall) begin
      paused_d = ~pause_n;
    end
  end

  // ----------------------------------------------------------------
  // two-entry write buffer between shifter and memory array
  // ----------------------------------------------------------------
  logic [7:0] buf_data_q [2];
  logic [7:0] buf_data_d [2];
  logic [9:0] buf_addr_q [2];
  logic [9:0] buf_addr_d [2];
  logic [1:0] buf_cnt_q, buf_cnt_d;
  logic buf_in_valid, buf_out_ready;
  logic [7:0] buf_in_data;
  logic [9:0] buf_in_addr;
  wire buf_in_ready = (buf_cnt_q != 2'h2);
  wire buf_out_valid = (buf_cnt_q != 2'h0);
  always_comb begin
    buf_data_d = buf_data_q;
    buf_addr_d = buf_addr_q;
    buf_cnt_d = buf_cnt_q;
    if (buf_out_valid && buf_out_ready) begin
      buf_data_d[0] = buf_data_q[1];
      buf_addr_d[0] = buf_addr_q[1];
      buf_cnt_d = buf_cnt_q - 2'h1;
    end
    if (buf_in_valid && buf_in_ready) begin
      buf_data_d[buf_cnt_d[0]] = buf_in_data;
      buf_addr_d[buf_cnt_d[0]] = buf_in_addr;
      buf_cnt_d = buf_cnt_d + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // serial sequencer
  // ----------------------------------------------------------------
  seei_state_t st_q, st_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0] bit_q, bit_d;
  logic [7:0] opc_q, opc_d;
  logic [9:0] ptr_q, ptr_d;
  logic [7:0] tx_q, tx_d;
  logic so_q, so_d;
  logic latch_q, latch_d;
  logic wr_armed_q, wr_armed_d;
  logic [1:0] bp_q, bp_d;
  logic pin_protect_enable_q, pin_protect_enable_d;
  logic busy_q, busy_d;
  logic [22:0] busy_cnt_q, busy_cnt_d;
  logic [7:0] rdata;
  logic mem_we;
  wire [7:0] status = {pin_protect_enable_q, 3'h0, bp_q, latch_q, busy_q};
  wire [9:0] page_mask = page_large_i ? 10'h01F : 10'h00F;

  // page wrap keeps the upper address bits of the page
  function automatic logic [9:0] page_next(input logic [9:0] a,
                                           input logic [9:0] m);
    page_next = (a & ~m) | ((a + 10'h001) & m);
  endfunction

  assign buf_out_ready = 1'b1;
  assign mem_we = buf_out_valid;
  assign buf_in_data = {sh_q[6:0], si};
  assign buf_in_addr = ptr_q;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    opc_d = opc_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    so_d = so_q;
    latch_d = latch_q;
    wr_armed_d = wr_armed_q;
    bp_d = bp_q;
    pin_protect_enable_d = pin_protect_enable_q;
    busy_d = busy_q;
    busy_cnt_d = busy_cnt_q;
    buf_in_valid = 1'b0;
    if (busy_q) begin
      if (busy_cnt_q == 23'(WRITE_CYCLES - 1)) begin
        busy_d = 1'b0;
        latch_d = 1'b0;
      end else begin
        busy_cnt_d = busy_cnt_q + 23'h1;
      end
    end
    if (cs_n) begin
      // select high ends the command at once; a running write cycle keeps counting and an armed write starts here
      st_d = SEEI_OPC;
      bit_d = BITCNT_RST;
      if (cs_rise) begin
        if (st_q == SEEI_IDLE && opc_q == OP_LATCH_SET && !busy_q) begin
          latch_d = 1'b1;
        end
        if (st_q == SEEI_IDLE && opc_q == OP_LATCH_CLEAR) begin
          latch_d = 1'b0;
        end
        if (wr_armed_q && bit_q == BITCNT_RST && !busy_q) begin
          busy_d = 1'b1;
          busy_cnt_d = 23'h0;
        end
      end
      wr_armed_d = 1'b0;
    end else if (!paused_q && sck_rise) begin
      sh_d = {sh_q[14:0], si};
      bit_d = bit_q + 5'h1;
      case (st_q)
        SEEI_OPC: begin
          if (bit_q == 5'(OPC_BITS - 1)) begin
            opc_d = {sh_q[6:0], si};
            bit_d = BITCNT_RST;
            case ({sh_q[6:0], si})
              OP_READ, OP_WRITE: st_d = SEEI_ADDR;
              OP_STATUS_READ: begin
                st_d = SEEI_SREAD;
                tx_d = status;
              end
              OP_STATUS_WRITE: st_d = SEEI_SWRITE;
              default: st_d = SEEI_IDLE;
            endcase
          end
        end
        SEEI_ADDR: begin
          if (bit_q == 5'(ADDR_BITS - 1)) begin
            ptr_d = {sh_q[8:0], si};
            bit_d = BITCNT_RST;
            if (opc_q == OP_READ) begin
              st_d = busy_q ? SEEI_IDLE : SEEI_RDATA;
            end else begin
              st_d = (latch_q && !busy_q) ? SEEI_WDATA : SEEI_IDLE;
            end
          end
        end
        SEEI_WDATA: begin
          wr_armed_d = 1'b0;
          if (bit_q == 5'(OPC_BITS - 1)) begin
            bit_d = BITCNT_RST;
            if (buf_in_ready) begin
              buf_in_valid = 1'b1;
              ptr_d = page_next(ptr_q, page_mask);
              wr_armed_d = 1'b1;
            end
          end
        end
        SEEI_RDATA: begin
          if (bit_q == 5'(OPC_BITS - 1)) begin
            bit_d = BITCNT_RST;
            ptr_d = ptr_q + 10'h001;
          end
        end
        SEEI_SWRITE: begin
          if (bit_q == 5'(OPC_BITS - 1)) begin
            bit_d = BITCNT_RST;
            st_d = SEEI_IDLE;
            if (latch_q && !busy_q) begin
              pin_protect_enable_d = sh_q[6];
              bp_d = sh_q[2:1];
              latch_d = 1'b0;
            end
          end
        end
        SEEI_SREAD: begin
          if (bit_q == 5'(OPC_BITS - 1)) begin
            bit_d = BITCNT_RST;
          end
        end
        default: begin
          // extra clocks spoil a latch command in this selection
          bit_d = BITCNT_RST;
          opc_d = 8'h00;
        end
      endcase
    end else if (!paused_q && sck_fall) begin
      // output changes after the falling edge, msb first
      if (st_q == SEEI_RDATA || st_q == SEEI_SREAD) begin
        so_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
        if (bit_q == BITCNT_RST && st_q == SEEI_SREAD) begin
          so_d = status[7];
          tx_d = {status[6:0], 1'b0};
        end
        if (bit_q == BITCNT_RST && st_q == SEEI_RDATA) begin
          so_d = rdata[7];
          tx_d = {rdata[6:0], 1'b0};
        end
      end
    end
  end

  // memory data settle long before the next serial clock fall
  logic [9:0] raddr;
  assign raddr = ptr_q;

  seei_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .we_i(mem_we),
    .waddr_i(buf_addr_q[0]),
    .wdata_i(buf_data_q[0]),
    .raddr_i(raddr),
    .rdata_o(rdata)
  );

  // output enable falls one cycle after the synced select is active and the synced pause inactive
  logic oe_n_q, oe_n_d;
  assign oe_n_d = cs_n | ~pause_n;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      paused_q <= 1'b0;
      st_q <= SEEI_OPC;
      sh_q <= 16'h0000;
      bit_q <= BITCNT_RST;
      opc_q <= 8'h00;
      ptr_q <= 10'h000;
      tx_q <= 8'h00;
      so_q <= 1'b0;
      latch_q <= 1'b0;
      wr_armed_q <= 1'b0;
      bp_q <= 2'h0;
      pin_protect_enable_q <= 1'b0;
      busy_q <= 1'b0;
      busy_cnt_q <= 23'h0;
      oe_n_q <= 1'b1;
      buf_cnt_q <= 2'h0;
      buf_data_q <= '{8'h00, 8'h00};
      buf_addr_q <= '{10'h000, 10'h000};
    end else begin
      paused_q <= paused_d;
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      opc_q <= opc_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
      so_q <= so_d;
      latch_q <= latch_d;
      wr_armed_q <= wr_armed_d;
      bp_q <= bp_d;
      pin_protect_enable_q <= pin_protect_enable_d;
      busy_q <= busy_d;
      busy_cnt_q <= busy_cnt_d;
      oe_n_q <= oe_n_d;
      buf_cnt_q <= buf_cnt_d;
      buf_data_q <= buf_data_d;
      buf_addr_q <= buf_addr_d;
    end
  end

  assign so_o = so_q;
  assign so_oe_n_o = oe_n_q;
  assign write_busy_flag_o = busy_q;
  assign write_latch_flag_o = latch_q;
endmodule

// [seei_top_monitor.sv]
// pin checker for the serial eeprom front end
// assumes a bind to seei_top; sees its ports only
`timescale 1ns/1ps
module seei_top_monitor #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic pause_n_i,
  input wire logic page_large_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  input wire logic write_busy_flag_o,
  input wire logic write_latch_flag_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----
  // busy length, counted since a fixed delay cannot span the cycle
  // ----
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;
  always_comb begin
    busy_cnt_d = write_busy_flag_o ? busy_cnt_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) busy_cnt_q <= 32'h0;
    else busy_cnt_q <= busy_cnt_d;
  end
  property p_cs_off; cs_n_i [*4] |-> so_oe_n_o; endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("output driven while deselected");
  property p_cs_rise; $rose(cs_n_i) |-> ##[1:4] so_oe_n_o; endproperty
  a_cs_rise: assert property (p_cs_rise)
    else $error("output kept after deselect");
  property p_hold_off;
    $fell(pause_n_i) && !cs_n_i |-> ##[1:4] so_oe_n_o;
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("output not released in pause");
  property p_hold_on;
    $rose(pause_n_i) && !cs_n_i |-> ##[1:4] !so_oe_n_o;
  endproperty
  a_hold_on: assert property (p_hold_on)
    else $error("output not driven after pause");
  property p_latch_cs; $rose(write_latch_flag_o) |-> cs_n_i; endproperty
  a_latch_cs: assert property (p_latch_cs)
    else $error("latch set while selected");
  property p_busy_cs;
    $rose(write_busy_flag_o) |-> cs_n_i && $past(cs_n_i);
  endproperty
  a_busy_cs: assert property (p_busy_cs)
    else $error("write began while selected");
  property p_busy_latch;
    $rose(write_busy_flag_o) |-> $past(write_latch_flag_o);
  endproperty
  a_busy_latch: assert property (p_busy_latch)
    else $error("write began without latch");
  property p_latch_end;
    $fell(write_busy_flag_o) |-> ##[0:2] !write_latch_flag_o;
  endproperty
  a_latch_end: assert property (p_latch_end)
    else $error("latch kept after write");
  property p_busy_len;
    $fell(write_busy_flag_o) |-> busy_cnt_q + 2 >= WRITE_CYCLES &&
      busy_cnt_q <= WRITE_CYCLES + 2;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
endmodule
bind seei_top seei_top_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon_i (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i),
  .sck_i(sck_i), .si_i(si_i), .pause_n_i(pause_n_i), .so_o(so_o),
  .page_large_i(page_large_i), .so_oe_n_o(so_oe_n_o),
  .write_busy_flag_o(write_busy_flag_o),
  .write_latch_flag_o(write_latch_flag_o));

// [seei_top_tb_top.sv]
// self-checking bench for the eeprom command front end
// assumes the host model and the bound pin checker
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR t=%0t got %0h exp %0h", $time, a, b); \
  end end
module seei_top_tb_top;
  import seei_pkg::*;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic page_large_i = 1'b1;
  logic cs_n, sck, si, pause_n, so, so_oe_n, busy, latch, off;
  logic [7:0] rx;
  logic [23:0] q;
  int num_errors = 0;
  int num_checks = 0;
  seei_top #(.WRITE_CYCLES(300)) seei_top_i (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .pause_n_i(pause_n), .page_large_i(page_large_i), .so_o(so),
    .so_oe_n_o(so_oe_n), .write_busy_flag_o(busy),
    .write_latch_flag_o(latch));
  seei_host_model seei_host_model_i (.clk_i(ref_clk_i), .so_i(so),
    .so_oe_n_i(so_oe_n), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
    .pause_n_o(pause_n));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // pin helpers
  // ----
  task automatic s(input logic on);
    seei_host_model_i.sel(on);
  endtask
  task automatic x(input logic [7:0] tx, input int n);
    seei_host_model_i.xfer(tx, n, rx);
  endtask
  task automatic cmd(input logic [7:0] op);
    s(1); x(op, 8); s(0);
  endtask
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    x(op, 8); x(a[15:8], 8); x(a[7:0], 8);
  endtask
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 400 && busy !== v; i++) @(posedge ref_clk_i);
    if (i == 400) begin num_errors++; conclude(); end
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [23:0] d);
    cmd(OP_LATCH_SET);
    s(1); hdr(OP_WRITE, a);
    for (int k = 0; k < n; k++) x(d[23-8*k -: 8], 8);
    s(0); wait_busy(1); wait_busy(0);
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    q = 24'h000000;
    s(1); hdr(OP_READ, a);
    for (int k = 0; k < n; k++) begin x(8'h00, 8); q[23-8*k -: 8] = rx; end
    s(0);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_latch;
    cmd(OP_LATCH_SET); `CHK(latch, 1'b1)
    cmd(8'hFF); `CHK(latch, 1'b1)
    cmd(OP_LATCH_CLEAR); `CHK(latch, 1'b0)
    s(1); x(OP_LATCH_SET, 8); hdr(OP_WRITE, 16'h0000); x(8'h11, 8); s(0);
    `CHK(busy, 1'b0)
    `CHK(latch, 1'b0)
    $display("t_latch done");
  endtask
  task automatic t_write;
    cmd(OP_LATCH_SET);
    s(1); hdr(OP_WRITE, 16'hFC1E); x(8'hA1, 8); x(8'hB2, 8); x(8'hC3, 8);
    s(0); wait_busy(1);
    s(1); x(OP_STATUS_READ, 8); x(8'h00, 8); s(0);
    `CHK(rx[BUSY_POS], 1'b1)
    `CHK(rx[LATCH_POS], 1'b1)
    wait_busy(0); `CHK(latch, 1'b0)
    rd(16'h041E, 2); `CHK(q[23:8], 16'hA1B2)
    rd(16'h0000, 1); `CHK(q[23:16], 8'hC3)
    $display("t_write done");
  endtask
  task automatic t_wrap;
    wr(16'h03FF, 1, 24'h5A0000);
    rd(16'hFFFF, 2); `CHK(q[23:8], 16'h5AC3)
    page_large_i <= 1'b0;
    wr(16'h000F, 2, 24'h112200);
    rd(16'h000F, 1); `CHK(q[23:16], 8'h11)
    rd(16'h0000, 1); `CHK(q[23:16], 8'h22)
    page_large_i <= 1'b1;
    $display("t_wrap done");
  endtask
  task automatic t_cancel;
    cmd(OP_LATCH_SET);
    s(1); hdr(OP_WRITE, 16'h0040); x(8'h77, 8); x(8'h55, 3); s(0);
    `CHK(busy, 1'b0)
    `CHK(latch, 1'b1)
    $display("t_cancel done");
  endtask
  task automatic t_pause;
    s(1); x(OP_READ, 8); x(8'hF0, 4);
    seei_host_model_i.hold(off);
    `CHK(off, 1'b1)
    `CHK(so_oe_n, 1'b0)
    x(8'hC0, 4); x(8'h1E, 8); x(8'h00, 8); s(0);
    `CHK(rx, 8'hA1)
    $display("t_pause done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_latch();
    t_write();
    t_wrap();
    t_cancel();
    t_pause();
    conclude();
  end
endmodule
